// ---- psrr_top.sv ----
// holds the apb slave and the two peripheral soft reset registers
// assumes an apb master on CLK_SYS and capability masks from logic on CLK_SYS
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "psrr_consts.svh"

module psrr_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] CAP_MASK_A,
  input wire logic [31:0] CAP_MASK_B,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  output logic PULSE_GEN_RESET,
  output logic CONVERTER_RESET,
  output logic HIBERNATION_RESET,
  output logic WATCHDOG_RESET,
  output logic COMPARATOR_B_RESET,
  output logic COMPARATOR_A_RESET,
  output logic GP_COUNTER3_RESET,
  output logic GP_COUNTER2_RESET,
  output logic GP_COUNTER1_RESET,
  output logic GP_COUNTER0_RESET,
  output logic TWO_WIRE_B_RESET,
  output logic TWO_WIRE_A_RESET,
  output logic QUADRATURE_B_RESET,
  output logic QUADRATURE_A_RESET,
  output logic SYNC_SERIAL_RESET,
  output logic ASYNC_SERIAL2_RESET,
  output logic ASYNC_SERIAL1_RESET,
  output logic ASYNC_SERIAL0_RESET
);
  psrr_pkg::psrr_apb_req_t req;
  psrr_pkg::psrr_top_t state_reg;
  psrr_pkg::psrr_top_t state_next;
  logic hit_a;
  logic hit_b;
  logic access;
  logic wr_a;
  logic wr_b;
  logic [31:0] word_a;
  logic [31:0] word_b;
  logic [3:0] resets_a;
  logic [13:0] resets_b;
  logic [3:0] out_a_reg;
  logic [13:0] out_b_reg;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // gather the request; decode the two word addresses
  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  assign access = req.sel & req.enable;
  assign hit_a = (req.addr == `PSRR_OFF_CTRL_A);
  assign hit_b = (req.addr == `PSRR_OFF_CTRL_B);
  assign wr_a = access & req.write & hit_a;
  assign wr_b = access & req.write & hit_b;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  // first word, gated by first capability mask
  psrr_masked_reg #(
    .IMPL(`PSRR_IMPL_A)
  ) u_ctrl_a (
    .clk(CLK_SYS),
    .rst(RST),
    .wr_en(wr_a),
    .wr_data(req.wdata),
    .cap_mask(CAP_MASK_A),
    .value(word_a)
  );

  // second word, gated by second capability mask
  psrr_masked_reg #(
    .IMPL(`PSRR_IMPL_B)
  ) u_ctrl_b (
    .clk(CLK_SYS),
    .rst(RST),
    .wr_en(wr_b),
    .wr_data(req.wdata),
    .cap_mask(CAP_MASK_B),
    .value(word_b)
  );

  // split words into peripheral resets
  psrr_fanout u_fanout (
    .word_a(word_a),
    .word_b(word_b),
    .resets_a(resets_a),
    .resets_b(resets_b)
  );

  // ------------------------------------------------------------
  // read data and error
  // ------------------------------------------------------------
  // read data captured in setup so it is ready in access phase
  always_comb
  begin
    state_next = state_reg;
    state_next.ctrl_a = word_a;
    state_next.ctrl_b = word_b;
    state_next.slverr = 1'b0;
    if (req.sel & ~req.enable)
    begin
      if (hit_a)
      begin
        state_next.rdata = word_a;
      end
      else if (hit_b)
      begin
        state_next.rdata = word_b;
      end
      else
      begin
        state_next.rdata = 32'h00000000;
        state_next.slverr = 1'b1; // unmapped address
      end
    end
    else if (~req.sel)
    begin
      state_next.rdata = 32'h00000000;
    end
    else
    begin
      // access phase: rdata holds; error drops after this edge
      state_next.rdata = state_reg.rdata;
    end
  end

  // registered bus state
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state_reg.rdata <= 32'h00000000;
      state_reg.slverr <= 1'b0;
      state_reg.ctrl_a <= `PSRR_RESET_VAL;
      state_reg.ctrl_b <= `PSRR_RESET_VAL;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // registered reset outputs
  // ------------------------------------------------------------
  // one flop stage so each output comes straight from a flop
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      out_a_reg <= 4'h0;
      out_b_reg <= 14'h0000;
    end
    else
    begin
      out_a_reg <= resets_a;
      out_b_reg <= resets_b;
    end
  end

  // ------------------------------------------------------------
  // output mapping
  // ------------------------------------------------------------
  assign PREADY = 1'b1; // zero wait states; a constant needs no flop
  assign PRDATA = state_reg.rdata;
  assign PSLVERR = state_reg.slverr; // set in setup, stands through access
  assign PULSE_GEN_RESET = out_a_reg[3];
  assign CONVERTER_RESET = out_a_reg[2];
  assign HIBERNATION_RESET = out_a_reg[1];
  assign WATCHDOG_RESET = out_a_reg[0];
  assign COMPARATOR_B_RESET = out_b_reg[13];
  assign COMPARATOR_A_RESET = out_b_reg[12];
  assign GP_COUNTER3_RESET = out_b_reg[11];
  assign GP_COUNTER2_RESET = out_b_reg[10];
  assign GP_COUNTER1_RESET = out_b_reg[9];
  assign GP_COUNTER0_RESET = out_b_reg[8];
  assign TWO_WIRE_B_RESET = out_b_reg[7];
  assign TWO_WIRE_A_RESET = out_b_reg[6];
  assign QUADRATURE_B_RESET = out_b_reg[5];
  assign QUADRATURE_A_RESET = out_b_reg[4];
  assign SYNC_SERIAL_RESET = out_b_reg[3];
  assign ASYNC_SERIAL2_RESET = out_b_reg[2];
  assign ASYNC_SERIAL1_RESET = out_b_reg[1];
  assign ASYNC_SERIAL0_RESET = out_b_reg[0];
endmodule // psrr_top

// ---- psrr_consts.svh ----
// holds offsets, field positions, reset values and masks of the reset bank
// assumes inclusion by bare name; definitions only
`ifndef PSRR_CONSTS_SVH
`define PSRR_CONSTS_SVH
// ------------------------------------------------------------
// addresses
// ------------------------------------------------------------
`define PSRR_BASE_ADDR 32'h400fe000
`define PSRR_OFF_CTRL_A 12'h040
`define PSRR_OFF_CTRL_B 12'h044
// ------------------------------------------------------------
// reset values and implemented bits
// ------------------------------------------------------------
`define PSRR_RESET_VAL 32'h00000000
`define PSRR_IMPL_A 32'h00110048
`define PSRR_IMPL_B 32'h030f5317
// ------------------------------------------------------------
// field positions, register a
// ------------------------------------------------------------
`define PSRR_A_PULSE_GEN 20
`define PSRR_A_CONVERTER 16
`define PSRR_A_HIBERNATION 6
`define PSRR_A_WATCHDOG 3
// ------------------------------------------------------------
// field positions, register b
// ------------------------------------------------------------
`define PSRR_B_COMPARATOR_B 25
`define PSRR_B_COMPARATOR_A 24
`define PSRR_B_COUNTER3 19
`define PSRR_B_COUNTER2 18
`define PSRR_B_COUNTER1 17
`define PSRR_B_COUNTER0 16
`define PSRR_B_TWO_WIRE_B 14
`define PSRR_B_TWO_WIRE_A 12
`define PSRR_B_QUADRATURE_B 9
`define PSRR_B_QUADRATURE_A 8
`define PSRR_B_SYNC_SERIAL 4
`define PSRR_B_ASYNC2 2
`define PSRR_B_ASYNC1 1
`define PSRR_B_ASYNC0 0
`endif

// ---- psrr_pkg.sv ----
// holds the types of the peripheral soft reset bank
// assumes nothing of its surroundings
package psrr_pkg;
  // apb request from the master
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } psrr_apb_req_t;

  // state of one masked control register
  typedef struct packed {
    logic [31:0] value;
  } psrr_word_t;

  // state of the top module
  typedef struct packed {
    logic [31:0] rdata;
    logic slverr;
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
  } psrr_top_t;
endpackage

// ---- psrr_masked_reg.sv ----
// holds one 32-bit control register whose writes are gated by a mask
// assumes a synchronous active high reset on the system clock
`timescale 1ns/1ps
`include "psrr_consts.svh"
module psrr_masked_reg #(
  parameter logic [31:0] IMPL = 32'h00000000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] cap_mask,
  output logic [31:0] value
);
  psrr_pkg::psrr_word_t state_reg;
  psrr_pkg::psrr_word_t state_next;
  logic [31:0] keep;

  // ------------------------------------------------------------
  // next value
  // ------------------------------------------------------------
  // only present, implemented bits take a write; others keep their value
  always_comb
  begin
    state_next = state_reg;
    keep = cap_mask & IMPL;
    if (wr_en)
    begin
      state_next.value = (state_reg.value & ~keep) | (wr_data & keep);
    end
    state_next.value = state_next.value & IMPL;
  end

  // register, cleared by system reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg.value <= `PSRR_RESET_VAL;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg.value;
endmodule // psrr_masked_reg

// ---- psrr_fanout.sv ----
// holds the split of the two control words into per-peripheral resets
// assumes words already registered; purely combinational
`timescale 1ns/1ps
`include "psrr_consts.svh"
module psrr_fanout (
  input wire logic [31:0] word_a,
  input wire logic [31:0] word_b,
  output logic [3:0] resets_a,
  output logic [13:0] resets_b
);
  // ------------------------------------------------------------
  // per-peripheral reset requests
  // ------------------------------------------------------------
  // a peripheral stays in reset while its bit is set
  always_comb
  begin
    resets_a = {word_a[`PSRR_A_PULSE_GEN], word_a[`PSRR_A_CONVERTER],
                word_a[`PSRR_A_HIBERNATION], word_a[`PSRR_A_WATCHDOG]};
    resets_b = {word_b[`PSRR_B_COMPARATOR_B], word_b[`PSRR_B_COMPARATOR_A],
                word_b[`PSRR_B_COUNTER3], word_b[`PSRR_B_COUNTER2],
                word_b[`PSRR_B_COUNTER1], word_b[`PSRR_B_COUNTER0],
                word_b[`PSRR_B_TWO_WIRE_B], word_b[`PSRR_B_TWO_WIRE_A],
                word_b[`PSRR_B_QUADRATURE_B], word_b[`PSRR_B_QUADRATURE_A],
                word_b[`PSRR_B_SYNC_SERIAL], word_b[`PSRR_B_ASYNC2],
                word_b[`PSRR_B_ASYNC1], word_b[`PSRR_B_ASYNC0]};
  end
endmodule // psrr_fanout

// ---- psrr_checker.sv ----
// checker of the reset bank apb slave and its reset outputs
// assumes a bind onto psrr_top, one clock domain
`timescale 1ns/1ps
`include "psrr_consts.svh"
module psrr_checker (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] CAP_MASK_A,
  input wire logic [31:0] CAP_MASK_B,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA,
  input wire logic PULSE_GEN_RESET,
  input wire logic WATCHDOG_RESET,
  input wire logic ASYNC_SERIAL0_RESET
);
  // ----------------------------------------
  // decode and assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  logic acc, rd_a, rd_b, wr_a, wr_b;
  // access phase decode
  assign acc = PSEL && PENABLE;
  assign rd_a = acc && !PWRITE && PADDR == `PSRR_OFF_CTRL_A;
  assign rd_b = acc && !PWRITE && PADDR == `PSRR_OFF_CTRL_B;
  assign wr_a = acc && PWRITE && PADDR == `PSRR_OFF_CTRL_A;
  assign wr_b = acc && PWRITE && PADDR == `PSRR_OFF_CTRL_B;
  chk_rst_clear: assert property ($past(RST) |-> PRDATA == 32'h0 && !WATCHDOG_RESET)
    else $error("not clear after reset");
  chk_err_unmap: assert property (acc && !rd_a && !rd_b && !wr_a && !wr_b
    |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (rd_a || rd_b || wr_a || wr_b |-> !PSLVERR)
    else $error("mapped access refused");
  chk_resv_a: assert property (rd_a |-> (PRDATA & ~`PSRR_IMPL_A) == 32'h0)
    else $error("reserved bit set in word a");
  chk_resv_b: assert property (rd_b |-> (PRDATA & ~`PSRR_IMPL_B) == 32'h0)
    else $error("reserved bit set in word b");
  chk_rd_fields: assert property (rd_a |-> PRDATA[20] == PULSE_GEN_RESET
    && PRDATA[3] == WATCHDOG_RESET)
    else $error("read bits differ from outputs");
  chk_wr_set: assert property (wr_a && PWDATA[3] && CAP_MASK_A[3] |=> ##1 WATCHDOG_RESET)
    else $error("watchdog reset not set");
  chk_wr_masked: assert property (wr_a && !CAP_MASK_A[3]
    |=> ##1 WATCHDOG_RESET == $past(WATCHDOG_RESET, 2))
    else $error("masked bit changed");
  chk_wr_clear: assert property (wr_b && !PWDATA[0] && CAP_MASK_B[0]
    |=> ##1 !ASYNC_SERIAL0_RESET)
    else $error("serial reset not released");
endmodule // psrr_checker

bind psrr_top psrr_checker u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .CAP_MASK_A(CAP_MASK_A), .CAP_MASK_B(CAP_MASK_B), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
  .PULSE_GEN_RESET(PULSE_GEN_RESET), .WATCHDOG_RESET(WATCHDOG_RESET),
  .ASYNC_SERIAL0_RESET(ASYNC_SERIAL0_RESET));

// ---- peripheral_soft_reset_regs_test.sv ----
// self-checking bench of the reset bank over apb
// assumes psrr_top and the checker on the compile path
`timescale 1ns/1ps
module peripheral_soft_reset_regs_test;
  // ----------------------------------------
  // stimulus and dut
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] mask_a = 32'hffffffff;
  logic [31:0] mask_b = 32'hffffffff;
  logic pready, pslverr, err;
  logic [31:0] prdata, rd;
  logic [17:0] outs;
  int miscompares = 0;
  int total_checks = 0;
  // clock of 100 ns
  always #50 clk_sys = ~clk_sys;
  psrr_top dut (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .CAP_MASK_A(mask_a),
    .CAP_MASK_B(mask_b), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .PULSE_GEN_RESET(outs[17]), .CONVERTER_RESET(outs[16]), .HIBERNATION_RESET(outs[15]),
    .WATCHDOG_RESET(outs[14]), .COMPARATOR_B_RESET(outs[13]), .COMPARATOR_A_RESET(outs[12]),
    .GP_COUNTER3_RESET(outs[11]), .GP_COUNTER2_RESET(outs[10]), .GP_COUNTER1_RESET(outs[9]),
    .GP_COUNTER0_RESET(outs[8]), .TWO_WIRE_B_RESET(outs[7]), .TWO_WIRE_A_RESET(outs[6]),
    .QUADRATURE_B_RESET(outs[5]), .QUADRATURE_A_RESET(outs[4]), .SYNC_SERIAL_RESET(outs[3]),
    .ASYNC_SERIAL2_RESET(outs[2]), .ASYNC_SERIAL1_RESET(outs[1]),
    .ASYNC_SERIAL0_RESET(outs[0]));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
  endtask
  // release the bus, then compare reset outputs with both words
  task automatic chk_outs(input logic [31:0] a, input logic [31:0] b);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({14'h0, outs}, {14'h0, a[20], a[16], a[6], a[3], b[25], b[24], b[19:16],
      b[14], b[12], b[9], b[8], b[4], b[2:0]});
  endtask
  // verdict
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(1'b0, 12'h040, 32'h0);
    check(rd, 32'h00000000);
    xfer(1'b0, 12'h044, 32'h0);
    check(rd, 32'h00000000);
    check({31'h0, err}, 32'h0);
    xfer(1'b1, 12'h040, 32'hffffffff);
    xfer(1'b1, 12'h044, 32'hffffffff);
    xfer(1'b0, 12'h040, 32'h0);
    check(rd, 32'h00110048);
    xfer(1'b0, 12'h044, 32'h0);
    check(rd, 32'h030f5317);
    chk_outs(32'h00110048, 32'h030f5317);
    mask_a <= 32'h00100000;
    mask_b <= 32'h00000001;
    xfer(1'b1, 12'h040, 32'h0);
    xfer(1'b1, 12'h044, 32'h0);
    xfer(1'b0, 12'h040, 32'h0);
    check(rd, 32'h00010048);
    xfer(1'b0, 12'h044, 32'h0);
    check(rd, 32'h030f5316);
    chk_outs(32'h00010048, 32'h030f5316);
    mask_a <= 32'hffffffff;
    mask_b <= 32'hffffffff;
    xfer(1'b1, 12'h000, 32'hffffffff);
    xfer(1'b0, 12'h048, 32'h0);
    check(rd, 32'h00000000);
    check({31'h0, err}, 32'h1);
    xfer(1'b0, 12'h040, 32'h0);
    check(rd, 32'h00010048);
    // second reset in mid-run clears both words
    psel <= 1'b0;
    penable <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(1'b0, 12'h040, 32'h0);
    check(rd, 32'h00000000);
    xfer(1'b0, 12'h044, 32'h0);
    check(rd, 32'h00000000);
    chk_outs(32'h0, 32'h0);
    xfer(1'b1, 12'h040, 32'h00000008);
    xfer(1'b1, 12'h044, 32'h00000001);
    chk_outs(32'h00000008, 32'h00000001);
    xfer(1'b1, 12'h040, 32'h0);
    xfer(1'b1, 12'h044, 32'h0);
    chk_outs(32'h0, 32'h0);
    tally_and_finish();
  end
  // hang guard
  initial
  begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
endmodule // peripheral_soft_reset_regs_test
